// ==== common/piu_cfg.svh ====
`ifndef PIU_CFG_SVH
`define PIU_CFG_SVH

// ----------------------------------------------------------------------------
// Line counts and widths
// ----------------------------------------------------------------------------
`define PIU_INT_LINES   8
`define PIU_EXT_LINES   24
`define PIU_EXT_BASIC   24'h00_00ff
`define PIU_ADDR_W      15

// ----------------------------------------------------------------------------
// Internal level positions, highest priority first
// ----------------------------------------------------------------------------
`define PIU_INT_PF      0
`define PIU_INT_TRAP    1
`define PIU_INT_CERR    2

// ----------------------------------------------------------------------------
// Fixed sub-sequence locations
// ----------------------------------------------------------------------------
`define PIU_VEC_INT     15'h0040
`define PIU_VEC_EXT     15'h0050

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PIU_MASK_RST    24'h00_0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PIU_CLK_NS      40
`define PIU_PF_WARN_NS  1000000

`endif

// ==== common/piu_pkg.sv ====
package piu_pkg;

  typedef logic [14:0] piu_addr_t;
  typedef logic [23:0] piu_ext_t;
  typedef logic [7:0]  piu_int_t;

  typedef enum logic [1:0] {
    PIU_SRC_NONE,
    PIU_SRC_INT,
    PIU_SRC_EXT
  } piu_src_t;

endpackage : piu_pkg

// ==== hdl/piu_prio.sv ====
`timescale 1ns/100ps

module piu_prio #(
  parameter int W  = 8,
  parameter int IW = 3
) (
  input  wire logic [W-1:0]  req_in,
  output logic               any_out,
  output logic      [IW-1:0] idx_out
);

  logic [W:0]    seen;
  logic [IW-1:0] idx_chain [W:0];

  assign seen[0]      = 1'b0;
  assign idx_chain[0] = '0;

  // Lowest index wins; a later bit only counts if nothing below it asked.
  for (genvar i = 0; i < W; i++) begin : g_chain
    assign seen[i+1]      = seen[i] | req_in[i];
    assign idx_chain[i+1] = (req_in[i] && !seen[i]) ? IW'(i) : idx_chain[i];
  end

  assign any_out = seen[W];
  assign idx_out = idx_chain[W];

endmodule : piu_prio

// ==== hdl/piu_sync.sv ====
`timescale 1ns/100ps

module piu_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_ff;

  // The first stage is read only by the second stage.
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      meta_ff <= '0;
      q_out   <= '0;
    end else begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end

endmodule : piu_sync

// ==== hdl/piu_top.sv ====
`timescale 1ns/100ps
`include "piu_cfg.svh"


module piu_top
  import piu_pkg::*;
#(
  parameter int PF_WARN_CYC = `PIU_PF_WARN_NS / `PIU_CLK_NS
) (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        pwr_warn_in,
  input  wire logic        emerg_in,
  input  wire logic [23:0] ext_irq_in,
  input  wire logic        ext_wide_in,
  input  wire logic        instr_done_in,
  input  wire logic        trap_op_in,
  input  wire logic        xfer_fail_in,
  input  wire logic        load_mask_instr_in,
  input  wire logic        exchange_mask_instr_in,
  input  wire logic [23:0] mask_wdata_in,
  input  wire logic        block_control_instr_a_in,
  input  wire logic        block_control_instr_b_in,
  input  wire logic        block_set_in,
  input  wire logic        control_and_skip_instr_in,
  input  wire logic        peripheral_control_branch_instr_in,
  input  wire logic        clr_pend_in,
  input  wire logic [4:0]  dev_sel_in,
  output logic             take_out,
  output piu_src_t         src_out,
  output piu_addr_t        vector_out,
  output piu_ext_t         mask_rdata_out,
  output piu_ext_t         ext_pend_out,
  output logic             block_out,
  output logic             xfer_abort_out,
  output logic             pf_window_out
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [26:0] sync_q;
  piu_sync #(.W(27)) u_sync (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .d_in    ({ext_wide_in, emerg_in, pwr_warn_in, ext_irq_in}),
    .q_out   (sync_q)
  );

  wire piu_ext_t ext_lvl  = sync_q[23:0];
  wire logic     pf_lvl   = sync_q[24];
  wire logic     em_lvl   = sync_q[25];
  wire logic     wide_lvl = sync_q[26];

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  piu_ext_t  ext_prev_ff;
  logic      pf_prev_ff;
  logic      em_prev_ff;
  piu_ext_t  ext_pend_ff;
  piu_int_t  int_pend_ff;
  piu_ext_t  mask_ff;
  logic      blk_ff;
  logic [14:0] pf_cnt_ff;

  // --------------------------------------------------------------------------
  // Event decode
  // --------------------------------------------------------------------------
  wire logic     pf_rise  = pf_lvl & ~pf_prev_ff;
  wire logic     em_rise  = em_lvl & ~em_prev_ff;
  wire piu_ext_t ext_en   = wide_lvl ? '1 : `PIU_EXT_BASIC;
  wire piu_ext_t ext_rise = ext_lvl & ~ext_prev_ff & ext_en;

  wire logic     clr_any  = clr_pend_in | control_and_skip_instr_in
                          | peripheral_control_branch_instr_in;
  wire piu_ext_t clr_vec  = clr_any ? piu_ext_t'(24'h00_0001 << dev_sel_in) : '0;

  // --------------------------------------------------------------------------
  // Arbitration
  // --------------------------------------------------------------------------
  logic       int_any;
  logic [2:0] int_idx;
  logic       ext_any;
  logic [4:0] ext_idx;

  wire piu_ext_t ext_elig = ext_pend_ff & mask_ff & ext_en & {24{~blk_ff}};

  piu_prio #(.W(8), .IW(3)) u_int_prio (
    .req_in  (int_pend_ff),
    .any_out (int_any),
    .idx_out (int_idx)
  );

  piu_prio #(.W(24), .IW(5)) u_ext_prio (
    .req_in  (ext_elig),
    .any_out (ext_any),
    .idx_out (ext_idx)
  );

  wire logic take_int = instr_done_in & int_any;
  wire logic take_ext = instr_done_in & ~int_any & ext_any;

  wire piu_addr_t int_vec = `PIU_VEC_INT + piu_addr_t'(int_idx);
  wire piu_addr_t ext_vec = `PIU_VEC_EXT + piu_addr_t'(ext_idx);

  wire piu_int_t int_clr = take_int ? piu_int_t'(8'h01 << int_idx) : '0;

  wire piu_int_t int_set = piu_int_t'({xfer_fail_in | em_rise, trap_op_in, pf_rise}
                                      << `PIU_INT_PF);

  // Set wins over clear so a request landing on the service cycle is kept.
  wire piu_int_t nxt_int_pend = (int_pend_ff & ~int_clr) | int_set;
  wire piu_ext_t nxt_ext_pend = ((ext_pend_ff & ~clr_vec) | ext_rise) & ext_en;

  wire logic blk_instr = block_control_instr_a_in | block_control_instr_b_in;
  wire logic nxt_blk = take_ext ? 1'b1 : (blk_instr ? block_set_in : blk_ff);

  wire logic mask_wr = load_mask_instr_in | exchange_mask_instr_in;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      ext_prev_ff <= '0;
      pf_prev_ff  <= 1'b0;
      em_prev_ff  <= 1'b0;
      ext_pend_ff <= '0;
      int_pend_ff <= '0;
      blk_ff      <= 1'b0;
    end else begin
      ext_prev_ff <= ext_lvl;
      pf_prev_ff  <= pf_lvl;
      em_prev_ff  <= em_lvl;
      ext_pend_ff <= nxt_ext_pend;
      int_pend_ff <= nxt_int_pend;
      blk_ff      <= nxt_blk;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      mask_ff        <= `PIU_MASK_RST;
      mask_rdata_out <= '0;
    end else begin
      if (mask_wr) begin
        mask_ff <= mask_wdata_in;
      end
      if (exchange_mask_instr_in) begin
        mask_rdata_out <= mask_ff;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      take_out   <= 1'b0;
      src_out    <= PIU_SRC_NONE;
      vector_out <= '0;
    end else begin
      take_out <= take_int | take_ext;
      if (take_int) begin
        src_out    <= PIU_SRC_INT;
        vector_out <= int_vec;
      end else if (take_ext) begin
        src_out    <= PIU_SRC_EXT;
        vector_out <= ext_vec;
      end
    end
  end

  // The warning window is a count, not a deadline the unit enforces; it only
  // tells the processor whether the hold-up time is still running.
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pf_cnt_ff      <= '0;
      xfer_abort_out <= 1'b0;
    end else begin
      xfer_abort_out <= pf_rise;
      if (pf_rise) begin
        pf_cnt_ff <= 15'(PF_WARN_CYC);
      end else if (pf_cnt_ff != '0) begin
        pf_cnt_ff <= pf_cnt_ff - 15'h0001;
      end
    end
  end

  assign pf_window_out = (pf_cnt_ff != '0);
  assign ext_pend_out  = ext_pend_ff;
  assign block_out     = blk_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  property p_int_first;
    take_ext |-> int_pend_ff == '0;
  endproperty
  a_int_first: assert property (p_int_first)
    else $error("External taken while internal pending.");

  property p_pf_top;
    (instr_done_in && int_pend_ff[0]) |=> take_out && vector_out == `PIU_VEC_INT;
  endproperty
  a_pf_top: assert property (p_pf_top)
    else $error("Power failure not serviced first.");

  property p_narrow;
    !wide_lvl |=> (ext_pend_ff & ~`PIU_EXT_BASIC) == '0;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("Upper external line pending in basic width.");

  property p_boundary;
    take_out |-> $past(instr_done_in);
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("Interrupt taken inside an instruction.");

  property p_trap;
    trap_op_in |=> int_pend_ff[1] || (take_out && vector_out == `PIU_VEC_INT + 15'h0001);
  endproperty
  a_trap: assert property (p_trap)
    else $error("Trap request lost.");

  property p_cerr;
    xfer_fail_in |=> int_pend_ff[2];
  endproperty
  a_cerr: assert property (p_cerr)
    else $error("Control error not raised.");

  property p_ext_vec;
    take_ext |=> vector_out == `PIU_VEC_EXT + piu_addr_t'($past(ext_idx))
                 && src_out == PIU_SRC_EXT;
  endproperty
  a_ext_vec: assert property (p_ext_vec)
    else $error("Wrong external vector.");

  property p_mask;
    take_ext |-> mask_ff[ext_idx] && ext_pend_ff[ext_idx];
  endproperty
  a_mask: assert property (p_mask)
    else $error("Masked line serviced.");

  property p_load;
    mask_wr |=> mask_ff == $past(mask_wdata_in);
  endproperty
  a_load: assert property (p_load)
    else $error("Mask not loaded.");

  property p_block;
    take_ext ##1 (!blk_instr)[*2] |-> !$past(take_ext) && blk_ff;
  endproperty
  a_block: assert property (p_block)
    else $error("Block not held after service.");

  property p_blk_prog;
    (blk_instr && !take_ext) |=> blk_ff == $past(block_set_in);
  endproperty
  a_blk_prog: assert property (p_blk_prog)
    else $error("Block control ignored.");

  property p_hold;
    (take_ext && !clr_any) |=> ext_pend_ff[$past(ext_idx)];
  endproperty
  a_hold: assert property (p_hold)
    else $error("Pending cleared by service.");

  property p_skip_clr;
    (control_and_skip_instr_in && dev_sel_in < 5'd24 && !ext_rise[dev_sel_in])
      |=> !ext_pend_ff[$past(dev_sel_in)];
  endproperty
  a_skip_clr: assert property (p_skip_clr)
    else $error("Status test did not clear pending.");

  property p_abort;
    pf_rise |=> xfer_abort_out ##1 !xfer_abort_out;
  endproperty
  a_abort: assert property (p_abort)
    else $error("Buffered transfer not aborted.");

  property p_lowest;
    take_ext |-> (ext_elig & ~(24'hff_ffff << ext_idx)) == '0;
  endproperty
  a_lowest: assert property (p_lowest)
    else $error("Lower external line skipped.");

endmodule : piu_top

// ==== verif/piu_dev_model.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Peripheral devices holding request levels
// ----------------------------------------------------------------------------
module piu_dev_model (
  input  wire logic        mclk_in,
  input  wire logic [23:0] raise_in,
  input  wire logic [23:0] drop_in,
  output logic      [23:0] irq_out
);
  initial irq_out = 24'h00_0000;
  // level held
  // A device keeps its level until the program tells it to drop it.
  always @(posedge mclk_in) begin
    irq_out <= (irq_out | raise_in) & ~drop_in;
  end
endmodule : piu_dev_model

// ==== verif/priority_interrupt_unit_test.sv ====
`timescale 1ns/100ps

module priority_interrupt_unit_test
  import piu_pkg::*;
;
  logic mclk_in, rstn_in, pwr_warn, emerg, wide, done, trap, xfail;
  logic ldm, xcm, bca, bcb, bset, cskip, pbranch, clrp;
  logic [23:0] wdata, raise, drop, irq, old;
  logic [4:0]  sel;
  logic        take_out, block_out, xfer_abort_out, pf_window_out;
  piu_src_t    src_out;
  piu_addr_t   vector_out;
  piu_ext_t    mask_rdata_out, ext_pend_out;
  logic [16:0] expq[$];
  logic [16:0] e;
  int          err_count, n_tests, n_abort;

  piu_dev_model dev (.mclk_in(mclk_in), .raise_in(raise), .drop_in(drop), .irq_out(irq));

  piu_top #(.PF_WARN_CYC(20)) dut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .pwr_warn_in(pwr_warn), .emerg_in(emerg),
    .ext_irq_in(irq), .ext_wide_in(wide), .instr_done_in(done), .trap_op_in(trap),
    .xfer_fail_in(xfail), .load_mask_instr_in(ldm), .exchange_mask_instr_in(xcm),
    .mask_wdata_in(wdata), .block_control_instr_a_in(bca),
    .block_control_instr_b_in(bcb), .block_set_in(bset),
    .control_and_skip_instr_in(cskip), .peripheral_control_branch_instr_in(pbranch),
    .clr_pend_in(clrp), .dev_sel_in(sel), .take_out(take_out), .src_out(src_out),
    .vector_out(vector_out), .mask_rdata_out(mask_rdata_out),
    .ext_pend_out(ext_pend_out), .block_out(block_out),
    .xfer_abort_out(xfer_abort_out), .pf_window_out(pf_window_out));

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  task chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task finish_test;
    $display("Checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc

  task instr(input bit t, input logic [16:0] v);
    @(posedge mclk_in);
    done <= 1'b1;
    if (t) expq.push_back(v);
    @(posedge mclk_in);
    done <= 1'b0;
  endtask : instr

  task mask_op(input bit x, input logic [23:0] d);
    @(posedge mclk_in);
    if (x) xcm <= 1'b1;
    else ldm <= 1'b1;
    wdata <= d;
    @(posedge mclk_in);
    xcm <= 1'b0;
    ldm <= 1'b0;
  endtask : mask_op

  task blk(input bit b, input logic s);
    @(posedge mclk_in);
    if (b) bcb <= 1'b1;
    else bca <= 1'b1;
    bset <= s;
    @(posedge mclk_in);
    bca <= 1'b0;
    bcb <= 1'b0;
  endtask : blk

  task clr(input int k, input logic [4:0] d);
    @(posedge mclk_in);
    sel <= d;
    if (k == 0) cskip <= 1'b1;
    else if (k == 1) pbranch <= 1'b1;
    else clrp <= 1'b1;
    drop <= 24'h00_0001 << d;
    @(posedge mclk_in);
    {cskip, pbranch, clrp} <= 3'b000;
    drop <= 24'h00_0000;
  endtask : clr

  task devr(input logic [23:0] r);
    @(posedge mclk_in);
    raise <= r;
    @(posedge mclk_in);
    raise <= 24'h00_0000;
  endtask : devr

  // ----------------------------------------------------------------------------
  // Take monitor
  // ----------------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (xfer_abort_out === 1'b1) n_abort++;
    if (take_out === 1'b1) begin
      if (expq.size() == 0) chk("unexpected take", 24'h1, 24'h0);
      else begin
        e = expq.pop_front();
        chk("vector", vector_out, e[14:0]);
        chk("src", src_out, e[16:15]);
      end
    end
  end

  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  initial begin
    {rstn_in, pwr_warn, emerg, done, trap, xfail, ldm, xcm, bca, bcb, bset} = 11'h000;
    {cskip, pbranch, clrp} = 3'b000;
    wide = 1'b1;
    wdata = 24'h00_0000;
    raise = 24'h00_0000;
    drop = 24'h00_0000;
    sel = 5'h00;
    void'($urandom(32'h88a7369f));
    cyc(6);
    rstn_in <= 1'b1;
    cyc(3);
    chk("pend", ext_pend_out, 24'h00_0000);
    chk("block", block_out, 24'h0);
    chk("src", src_out, PIU_SRC_NONE);
    $display("test reset done");
    // Internals win even with the block set by program.
    blk(0, 1'b1);
    cyc(1);
    chk("block", block_out, 24'h1);
    @(posedge mclk_in);
    {pwr_warn, trap, xfail} <= 3'b111;
    @(posedge mclk_in);
    {trap, xfail} <= 2'b00;
    cyc(6);
    chk("pf window", pf_window_out, 24'h1);
    chk("abort", n_abort, 24'h1);
    instr(1, {PIU_SRC_INT, 15'h0040});
    instr(1, {PIU_SRC_INT, 15'h0041});
    instr(1, {PIU_SRC_INT, 15'h0042});
    $display("test internal done");
    blk(1, 1'b0);
    mask_op(0, 24'h10_0024);
    devr(24'h00_002c);
    cyc(5);
    chk("pend", ext_pend_out, 24'h00_002c);
    instr(1, {PIU_SRC_EXT, 15'h0052});
    cyc(2);
    chk("block", block_out, 24'h1);
    chk("pf window end", pf_window_out, 24'h0);
    chk("pend", ext_pend_out, 24'h00_002c);
    instr(0, 17'h0);
    clr(0, 5'd2);
    blk(1, 1'b0);
    instr(1, {PIU_SRC_EXT, 15'h0055});
    clr(1, 5'd5);
    clr(2, 5'd3);
    cyc(2);
    chk("pend", ext_pend_out, 24'h00_0000);
    blk(0, 1'b0);
    devr(24'h10_0000);
    cyc(5);
    instr(1, {PIU_SRC_EXT, 15'h0064});
    blk(0, 1'b0);
    @(posedge mclk_in);
    wide <= 1'b0;
    cyc(4);
    chk("narrow pend", ext_pend_out, 24'h00_0000);
    instr(0, 17'h0);
    $display("test external done");
    old = 24'($urandom());
    mask_op(1, old);
    cyc(1);
    chk("xchg old", mask_rdata_out, 24'h10_0024);
    mask_op(1, 24'h00_0000);
    cyc(1);
    chk("xchg old", mask_rdata_out, old);
    @(posedge mclk_in);
    emerg <= 1'b1;
    cyc(5);
    instr(1, {PIU_SRC_INT, 15'h0042});
    cyc(4);
    chk("missing takes", expq.size(), 24'h0);
    $display("test mask and emergency done");
    finish_test();
  end
endmodule : priority_interrupt_unit_test
